// ===== hw/epso_consts.svh
`ifndef EPSO_CONSTS_SVH
`define EPSO_CONSTS_SVH

// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define EPSO_OP_PTR_ADD      8'hE8
`define EPSO_OP_MOVE_IDX     8'hEB
`define EPSO_OP_CALL_WORK    16'h0014
`define EPSO_SEL_FRAME       2'h3
`define EPSO_SECOND_NIBBLE   4'hF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define EPSO_SEL_HI          7
`define EPSO_SEL_LO          6
`define EPSO_LIT6_HI         5
`define EPSO_LIT7_HI         6
`define EPSO_MOVE_FORM_BIT   7

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define EPSO_PTR_W           12
`define EPSO_PC_W            21
`define EPSO_PC_STEP         21'h00_0002
`define EPSO_PTR_RST         12'h000
`define EPSO_INDIRECT_DATA   8'h00

`endif

// ===== hw/epso_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "epso_consts.svh"

module epso_decode
(
  input  wire logic [15:0]      i_word,
  input  wire logic             i_ext_en,
  output var  epso_pkg::epso_op_t o_op
);

  // ----------------------------------------
  // Opcode classification
  // ----------------------------------------
  always_comb
  begin
    o_op = epso_pkg::EPSO_OP_NONE;
    if (i_ext_en)
    begin
      if (i_word[15:8] == `EPSO_OP_PTR_ADD)
      begin
        if (i_word[`EPSO_SEL_HI:`EPSO_SEL_LO] == `EPSO_SEL_FRAME)
          o_op = epso_pkg::EPSO_OP_FADD;
        else
          o_op = epso_pkg::EPSO_OP_PADD;
      end
      else if (i_word == `EPSO_OP_CALL_WORK)
        o_op = epso_pkg::EPSO_OP_CALL;
      else if (i_word[15:8] == `EPSO_OP_MOVE_IDX && !i_word[`EPSO_MOVE_FORM_BIT])
        o_op = epso_pkg::EPSO_OP_MOVE;
    end
  end

endmodule
`default_nettype wire

// ===== hw/epso_exec.sv
// Notes on behaviour
// - Pointer add adds 6-bit literal to pointer 0..2; one cycle, no flags.
// - Frame add-and-return adds literal to frame pointer, then pops stack into PC.
// - Pointer add with select 11 is the frame add-and-return form.
// - Frame add-and-return takes two cycles; second is a no-operation.
// - Call via working register pushes PC plus 2 first.
// - Call loads PC low from working register, high and upper from latches.
// - Call takes two cycles; never touches working, status or bank registers.
// - Move source address is frame pointer plus 7-bit offset.
// - Move destination is 12-bit literal of second word, top nibble 1111.
// - Source hitting an indirect register yields 00h as moved data.
// - Extended opcodes decode only while the enable bit is set.
`timescale 1ns/1ps
`default_nettype none
`include "epso_consts.svh"

module epso_exec
#(
  parameter int PTR_W = `EPSO_PTR_W,
  parameter int PC_W  = `EPSO_PC_W
)
(
  input  wire logic              i_core_clk,
  input  wire logic              i_sys_rst,
  input  wire logic              i_ext_set_enable_bit,
  input  wire logic              i_instr_valid,
  input  wire logic [15:0]       i_instr_word,
  input  wire logic [PC_W-1:0]   i_pc,
  input  wire logic [7:0]        i_working_register,
  input  wire logic [7:0]        i_pc_high_latch,
  input  wire logic [7:0]        i_pc_upper_latch,
  input  wire logic [PC_W-1:0]   i_top_of_return_stack,
  input  wire logic [7:0]        i_mem_rdata,
  input  wire logic              i_mem_rd_indirect,
  output logic [PTR_W-1:0]       o_file_pointer0,
  output logic [PTR_W-1:0]       o_file_pointer1,
  output logic [PTR_W-1:0]       o_stack_frame_pointer,
  output logic                   o_pc_load,
  output logic [PC_W-1:0]        o_pc_next,
  output logic                   o_stack_push,
  output logic [PC_W-1:0]        o_stack_push_data,
  output logic                   o_stack_pop,
  output logic                   o_mem_rd,
  output logic [PTR_W-1:0]       o_mem_raddr,
  output logic                   o_mem_wr,
  output logic [PTR_W-1:0]       o_mem_waddr,
  output logic [7:0]             o_mem_wdata,
  output logic                   o_busy,
  output logic                   o_illegal_second
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  epso_pkg::epso_op_t    op;
  epso_pkg::epso_state_t state_q;
  logic [PTR_W-1:0]      fp_q [3];
  logic [PTR_W-1:0]      lit6;
  logic [PTR_W-1:0]      lit7;
  logic [1:0]            sel;
  logic                  take;
  logic [7:0]            move_data_q;

  epso_decode epso_decode_i
  (
    .i_word   (i_instr_word),
    .i_ext_en (i_ext_set_enable_bit),
    .o_op     (op)
  );

  assign take = i_instr_valid && (state_q == epso_pkg::EPSO_ST_IDLE);
  assign sel  = i_instr_word[`EPSO_SEL_HI:`EPSO_SEL_LO];
  assign lit6 = PTR_W'(i_instr_word[`EPSO_LIT6_HI:0]);
  assign lit7 = PTR_W'(i_instr_word[`EPSO_LIT7_HI:0]);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_q <= epso_pkg::EPSO_ST_IDLE;
    else
    begin
      unique case (state_q)
        epso_pkg::EPSO_ST_IDLE:
        begin
          if (take && (op == epso_pkg::EPSO_OP_FADD || op == epso_pkg::EPSO_OP_CALL))
            state_q <= epso_pkg::EPSO_ST_NOP;
          else if (take && op == epso_pkg::EPSO_OP_MOVE)
            state_q <= epso_pkg::EPSO_ST_MOVE2;
        end
        epso_pkg::EPSO_ST_NOP:
          state_q <= epso_pkg::EPSO_ST_IDLE;
        epso_pkg::EPSO_ST_MOVE2:
        begin
          if (i_instr_valid)
            state_q <= epso_pkg::EPSO_ST_IDLE;
        end
        default:
          state_q <= epso_pkg::EPSO_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Pointer file
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fp_q[0] <= `EPSO_PTR_RST;
      fp_q[1] <= `EPSO_PTR_RST;
      fp_q[2] <= `EPSO_PTR_RST;
    end
    else if (take && op == epso_pkg::EPSO_OP_PADD)
      fp_q[sel] <= fp_q[sel] + lit6;
    else if (take && op == epso_pkg::EPSO_OP_FADD)
      fp_q[2] <= fp_q[2] + lit6;
  end

  // ----------------------------------------
  // Program counter and return stack
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_pc_load         <= 1'b0;
      o_pc_next         <= '0;
      o_stack_push      <= 1'b0;
      o_stack_push_data <= '0;
      o_stack_pop       <= 1'b0;
    end
    else
    begin
      o_pc_load    <= 1'b0;
      o_stack_push <= 1'b0;
      o_stack_pop  <= 1'b0;
      if (take && op == epso_pkg::EPSO_OP_FADD)
      begin
        o_stack_pop <= 1'b1;
        o_pc_load   <= 1'b1;
        o_pc_next   <= i_top_of_return_stack;
      end
      else if (take && op == epso_pkg::EPSO_OP_CALL)
      begin
        o_stack_push      <= 1'b1;
        o_stack_push_data <= i_pc + `EPSO_PC_STEP;
        o_pc_load         <= 1'b1;
        o_pc_next         <= PC_W'({i_pc_upper_latch[4:0], i_pc_high_latch,
                                    i_working_register});
      end
    end
  end

  // ----------------------------------------
  // Indexed to absolute move
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_mem_rd         <= 1'b0;
      o_mem_raddr      <= '0;
      o_mem_wr         <= 1'b0;
      o_mem_waddr      <= '0;
      o_mem_wdata      <= '0;
      o_illegal_second <= 1'b0;
      move_data_q      <= '0;
    end
    else
    begin
      o_mem_rd         <= 1'b0;
      o_mem_wr         <= 1'b0;
      o_illegal_second <= 1'b0;
      if (take && op == epso_pkg::EPSO_OP_MOVE)
      begin
        o_mem_rd    <= 1'b1;
        o_mem_raddr <= fp_q[2] + lit7;
      end
      if (o_mem_rd)
        move_data_q <= i_mem_rd_indirect ? `EPSO_INDIRECT_DATA : i_mem_rdata;
      if (state_q == epso_pkg::EPSO_ST_MOVE2 && i_instr_valid)
      begin
        if (i_instr_word[15:12] == `EPSO_SECOND_NIBBLE)
        begin
          o_mem_wr    <= 1'b1;
          o_mem_waddr <= i_instr_word[11:0];
          o_mem_wdata <= o_mem_rd ? (i_mem_rd_indirect ? `EPSO_INDIRECT_DATA
                                                       : i_mem_rdata)
                                  : move_data_q;
        end
        else
          o_illegal_second <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Visible state
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_file_pointer0       <= `EPSO_PTR_RST;
      o_file_pointer1       <= `EPSO_PTR_RST;
      o_stack_frame_pointer <= `EPSO_PTR_RST;
      o_busy                <= 1'b0;
    end
    else
    begin
      o_file_pointer0       <= fp_q[0];
      o_file_pointer1       <= fp_q[1];
      o_stack_frame_pointer <= fp_q[2];
      o_busy                <= (state_q != epso_pkg::EPSO_ST_IDLE);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_padd;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && op == epso_pkg::EPSO_OP_PADD && sel == 2'h0)
      |=> (fp_q[0] == $past(fp_q[0]) + $past(lit6));
  endproperty
  a_padd: assert property (p_padd) else $error("pointer add wrong");

  property p_fadd;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && op == epso_pkg::EPSO_OP_FADD)
      |=> (fp_q[2] == $past(fp_q[2]) + $past(lit6)) && o_stack_pop && o_pc_load;
  endproperty
  a_fadd: assert property (p_fadd) else $error("frame add-return wrong");

  property p_sel3;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && op == epso_pkg::EPSO_OP_FADD) |=> (fp_q[0] == $past(fp_q[0]));
  endproperty
  a_sel3: assert property (p_sel3) else $error("select 11 touched pointer 0");

  property p_two_cycle;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && (op == epso_pkg::EPSO_OP_FADD || op == epso_pkg::EPSO_OP_CALL))
      |=> (state_q == epso_pkg::EPSO_ST_NOP) ##1 (state_q == epso_pkg::EPSO_ST_IDLE);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two-cycle op wrong");

  property p_push;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && op == epso_pkg::EPSO_OP_CALL)
      |=> o_stack_push && (o_stack_push_data == $past(i_pc) + `EPSO_PC_STEP);
  endproperty
  a_push: assert property (p_push) else $error("call push wrong");

  property p_call_pc;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && op == epso_pkg::EPSO_OP_CALL)
      |=> (o_pc_next[7:0] == $past(i_working_register))
          && (o_pc_next[15:8] == $past(i_pc_high_latch));
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target wrong");

  property p_src;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (take && op == epso_pkg::EPSO_OP_MOVE)
      |=> o_mem_rd && (o_mem_raddr == $past(fp_q[2]) + $past(lit7));
  endproperty
  a_src: assert property (p_src) else $error("move source wrong");

  property p_dst;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (state_q == epso_pkg::EPSO_ST_MOVE2 && i_instr_valid && i_instr_word[15:12] == 4'hF)
      |=> o_mem_wr && (o_mem_waddr == $past(i_instr_word[11:0]));
  endproperty
  a_dst: assert property (p_dst) else $error("move destination wrong");

  property p_ind;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    (o_mem_rd && i_mem_rd_indirect) |=> (move_data_q == 8'h00);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect source not zero");

  property p_off;
    @(posedge i_core_clk) disable iff (i_sys_rst)
    !i_ext_set_enable_bit |-> (op == epso_pkg::EPSO_OP_NONE);
  endproperty
  a_off: assert property (p_off) else $error("decode while disabled");

endmodule
`default_nettype wire

// ===== hw/epso_pkg.sv
package epso_pkg;

  typedef enum logic [1:0]
  {
    EPSO_ST_IDLE  = 2'b00,
    EPSO_ST_NOP   = 2'b01,
    EPSO_ST_MOVE2 = 2'b10
  } epso_state_t;

  typedef enum logic [2:0]
  {
    EPSO_OP_NONE   = 3'b000,
    EPSO_OP_PADD   = 3'b001,
    EPSO_OP_FADD   = 3'b010,
    EPSO_OP_CALL   = 3'b011,
    EPSO_OP_MOVE   = 3'b100
  } epso_op_t;

endpackage

// ===== tb/epso_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Data memory and return stack
// ----------------------------------------
module epso_far_model
#(
  parameter logic [20:0] STACK_INIT = 21'h00_0000,
  parameter logic [11:0] IND_ADDR = 12'h000
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_mem_rd,
  input  wire logic [11:0] i_mem_raddr,
  input  wire logic        i_stack_push,
  input  wire logic [20:0] i_stack_push_data,
  input  wire logic        i_stack_pop,
  output logic [7:0]       o_mem_rdata,
  output logic             o_mem_rd_indirect,
  output logic [20:0]      o_top_of_return_stack
);
  logic [20:0] below_q;

  // Read data stands while the read stands, inverse of it otherwise
  assign o_mem_rdata       = i_mem_rd ? (i_mem_raddr[7:0] ^ 8'h5A)
                                      : ~(i_mem_raddr[7:0] ^ 8'h5A);
  assign o_mem_rd_indirect = i_mem_rd && (i_mem_raddr == IND_ADDR);

  // Two-level stack
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
    if (i_sys_rst)
    begin
      o_top_of_return_stack <= STACK_INIT;
      below_q               <= STACK_INIT;
    end
    else if (i_stack_push)
    begin
      below_q               <= o_top_of_return_stack;
      o_top_of_return_stack <= i_stack_push_data;
    end
    else if (i_stack_pop)
      o_top_of_return_stack <= below_q;
endmodule
`default_nettype wire

// ===== tb/extended_pointer_stack_ops_tb.sv
`timescale 1ns/1ps
`default_nettype none

module extended_pointer_stack_ops_tb;
  localparam logic [20:0] STACK_INIT = 21'h01_2345;
  localparam logic [11:0] IND_ADDR = 12'h050;
  logic clk = 1'b0, rst = 1'b1, ext_en = 1'b0, valid = 1'b0;
  logic [15:0] word = 16'h0000;
  logic [20:0] pc = 21'h00_0000;
  logic [7:0] work_reg = 8'h00, hlat = 8'h00, ulat = 8'h00;
  logic [20:0] top_of_return_stack, pc_next, push_d, cap_pc, cap_push;
  logic [11:0] fp0, fp1, frame, raddr, waddr, cap_ra, cap_wa, src;
  logic [7:0] rdata, wdata, cap_wd;
  logic ind, pc_load, push, pop, rd, wr, busy, ill;
  int error_cnt = 0, compares = 0;
  int n_load = 0, n_push = 0, n_pop = 0, n_rd = 0, n_wr = 0, n_ill = 0, n_busy = 0;
  logic [6:0] mz [3] = '{7'h05, 7'h7F, 7'h0D};
  logic [11:0] md [3] = '{12'h123, 12'h7FE, 12'h000};

  always #2 clk = ~clk;

  epso_exec epso_exec_i (.i_core_clk(clk), .i_sys_rst(rst), .i_ext_set_enable_bit(ext_en),
    .i_instr_valid(valid), .i_instr_word(word), .i_pc(pc), .i_working_register(work_reg),
    .i_pc_high_latch(hlat), .i_pc_upper_latch(ulat), .i_top_of_return_stack(top_of_return_stack),
    .i_mem_rdata(rdata), .i_mem_rd_indirect(ind), .o_file_pointer0(fp0),
    .o_file_pointer1(fp1), .o_stack_frame_pointer(frame), .o_pc_load(pc_load),
    .o_pc_next(pc_next), .o_stack_push(push), .o_stack_push_data(push_d), .o_stack_pop(pop),
    .o_mem_rd(rd), .o_mem_raddr(raddr), .o_mem_wr(wr), .o_mem_waddr(waddr),
    .o_mem_wdata(wdata), .o_busy(busy), .o_illegal_second(ill));

  epso_far_model #(.STACK_INIT(STACK_INIT), .IND_ADDR(IND_ADDR)) epso_far_model_i (
    .i_core_clk(clk), .i_sys_rst(rst), .i_mem_rd(rd), .i_mem_raddr(raddr),
    .i_stack_push(push), .i_stack_push_data(push_d), .i_stack_pop(pop),
    .o_mem_rdata(rdata), .o_mem_rd_indirect(ind), .o_top_of_return_stack(top_of_return_stack));

  // ----------------------------------------
  // Pulse counters and captures
  // ----------------------------------------
  always @(negedge clk)
  begin
    if (pc_load === 1'b1) n_load <= n_load + 1;
    if (pc_load === 1'b1) cap_pc <= pc_next;
    if (push === 1'b1) n_push <= n_push + 1;
    if (push === 1'b1) cap_push <= push_d;
    if (pop === 1'b1) n_pop <= n_pop + 1;
    if (rd === 1'b1) n_rd <= n_rd + 1;
    if (rd === 1'b1) cap_ra <= raddr;
    if (wr === 1'b1) n_wr <= n_wr + 1;
    if (wr === 1'b1) cap_wa <= waddr;
    if (wr === 1'b1) cap_wd <= wdata;
    if (ill === 1'b1) n_ill <= n_ill + 1;
    if (busy === 1'b1) n_busy <= n_busy + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic drive(input logic [15:0] w);
    @(posedge clk);
    word  <= w;
    valid <= 1'b1;
  endtask

  task automatic idle;
    @(posedge clk);
    valid <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task complete_run;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    complete_run;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("fp0", 21'(12'h000), 21'(fp0));
    chk("frame", 21'(12'h000), 21'(frame));
    $display("test reset ended");
    drive(16'hE805);
    drive(16'h0014);
    idle;
    chk("fp0", 21'(12'h000), 21'(fp0));
    chk("loads", 21'(0), 21'(n_load));
    $display("test disabled ended");
    @(posedge clk);
    ext_en <= 1'b1;
    drive(16'hE83F);
    drive(16'hE841);
    drive(16'hE8BF);
    drive(16'hE881);
    idle;
    chk("fp0", 21'(12'h03F), 21'(fp0));
    chk("fp1", 21'(12'h001), 21'(fp1));
    chk("frame", 21'(12'h040), 21'(frame));
    chk("loads", 21'(0), 21'(n_load));
    $display("test pointer add ended");
    drive(16'hE8C3);
    drive(16'hE805);
    idle;
    chk("frame", 21'(12'h043), 21'(frame));
    chk("fp0", 21'(12'h03F), 21'(fp0));
    chk("pops", 21'(1), 21'(n_pop));
    chk("loads", 21'(1), 21'(n_load));
    chk("pc", STACK_INIT, cap_pc);
    chk("busy", 21'(1), 21'(n_busy));
    $display("test add return ended");
    @(posedge clk);
    pc   <= 21'h0A_BCDE;
    work_reg <= 8'h06;
    hlat <= 8'h10;
    ulat <= 8'hE7;
    drive(16'h0014);
    drive(16'hE805);
    idle;
    chk("pushes", 21'(1), 21'(n_push));
    chk("push data", 21'h0A_BCE0, cap_push);
    chk("loads", 21'(2), 21'(n_load));
    chk("pc", 21'h07_1006, cap_pc);
    chk("fp0", 21'(12'h03F), 21'(fp0));
    drive(16'hE8C0);
    idle;
    chk("pc", 21'h0A_BCE0, cap_pc);
    chk("frame", 21'(12'h043), 21'(frame));
    chk("busy", 21'(3), 21'(n_busy));
    $display("test call ended");
    for (int i = 0; i < 3; i++)
    begin
      src = 12'h043 + 12'(mz[i]);
      drive({8'hEB, 1'b0, mz[i]});
      drive({4'hF, md[i]});
      idle;
      chk("reads", 21'(i + 1), 21'(n_rd));
      chk("raddr", 21'(src), 21'(cap_ra));
      chk("writes", 21'(i + 1), 21'(n_wr));
      chk("waddr", 21'(md[i]), 21'(cap_wa));
      chk("wdata", 21'((src == IND_ADDR) ? 8'h00 : (src[7:0] ^ 8'h5A)), 21'(cap_wd));
      chk("busy", 21'(i + 4), 21'(n_busy));
    end
    drive(16'hEB05);
    drive(16'hE123);
    idle;
    chk("illegal", 21'(1), 21'(n_ill));
    chk("writes", 21'(3), 21'(n_wr));
    $display("test move ended");
    complete_run;
  end
endmodule
`default_nettype wire
